// ---- hdl/dif_pkg.sv ----
// Constants shared by the drive input function logic.
// Assumes a single 125 MHz system clock domain.
package dif_pkg;
    localparam int NUM_TERMS = 7;
    localparam int FUNC_W    = 5;
    // Function codes assignable to a terminal.
    localparam logic [4:0] FN_NONE       = 5'h00;
    localparam logic [4:0] FN_MANUAL     = 5'h0A;
    localparam logic [4:0] FN_ALT_MOTOR  = 5'h0B;
    localparam logic [4:0] FN_XCEL_L     = 5'h0C;
    localparam logic [4:0] FN_XCEL_H     = 5'h0D;
    localparam logic [4:0] FN_RUN_LATCH  = 5'h0E;
    localparam logic [4:0] FN_EXT_TRIP   = 5'h0F;
    localparam logic [4:0] FN_BLOCK_POS  = 5'h10;
    localparam logic [4:0] FN_BLOCK_NEG  = 5'h11;
    localparam logic [4:0] FN_LOOP_INH   = 5'h12;
    localparam logic [4:0] FN_TIMER_IN   = 5'h13;
    localparam logic [4:0] FN_RAMP_BYP   = 5'h14;
    // Loop controller mode values.
    localparam logic [1:0] LOOP_DISABLE  = 2'h0;
    localparam logic [1:0] LOOP_ENABLE   = 2'h1;
    localparam logic [1:0] LOOP_TERMINAL = 2'h2;
    // Delay timer: settings in tenths of a second.
    localparam int DELAY_MIN_TENTHS = 1;
    localparam int DELAY_MAX_TENTHS = 36000;
    localparam int CLK_MHZ          = 125;
    localparam int TENTH_NS         = 100000000;
    localparam int TENTH_CYCLES     = TENTH_NS / 8;
    localparam int BLINK_TENTHS     = 2;
    // Register offsets (byte addresses).
    localparam logic [7:0] OFS_ASSIGN0  = 8'h00;
    localparam logic [7:0] OFS_ASSIGN1  = 8'h04;
    localparam logic [7:0] OFS_CONFIG   = 8'h08;
    localparam logic [7:0] OFS_PARAMS   = 8'h0C;
    localparam logic [7:0] OFS_DELAYS   = 8'h10;
    localparam logic [7:0] OFS_STATUS   = 8'h14;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h1C;
    localparam logic [7:0] OFS_DRIVE    = 8'h20;
    // Reset values.
    localparam logic [15:0] RST_DELAY   = 16'h000A;
    localparam logic [1:0]  RST_LOOP    = LOOP_DISABLE;
    // Interrupt status bits.
    localparam int IRQ_TRIP    = 0;
    localparam int IRQ_CONFL   = 1;
    localparam int IRQ_REFUSED = 2;
    localparam int IRQ_SWITCH  = 3;
    localparam int IRQ_W       = 4;
endpackage

// ---- hdl/dif_input_logic.sv ----
// Drive input terminal function decoding with an AHB-Lite register slave.
// Assumes terminals are asynchronous pins and motorStopped comes from the control core.
//
// Register access over AHB-Lite and the register offsets were decided locally.
`timescale 1ns/10ps
module dif_input_logic #(
    parameter int SPEED_W      = 16,
    parameter int TENTH_CYCLES = dif_pkg::TENTH_CYCLES
) (
    // Clock and reset
    input  wire logic                      ref_clk,
    input  wire logic                      rstn,
    // AHB-Lite slave
    input  wire logic                      hsel,
    input  wire logic [7:0]                haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic [31:0]               hwdata,
    input  wire logic                      hready,
    output logic      [31:0]               hrdata,
    output logic                           hreadyout,
    output logic                           hresp,
    // Terminals and run pins
    input  wire logic [6:0]                termIn,
    input  wire logic                      fwdRunPin,
    input  wire logic                      revRunPin,
    input  wire logic                      stopPin,
    // Control core
    input  wire logic                      motorStopped,
    input  wire logic                      keypadWrite,
    input  wire logic [31:0]               keypadData,
    input  wire logic signed [SPEED_W-1:0] speedCmdIn,
    input  wire logic                      loopOutIn,
    input  wire logic                      faultReset,
    // Outputs to core, keypad and terminals
    output logic signed [SPEED_W-1:0]      speedCmdOut,
    output logic                           fwdRunCmd,
    output logic                           revRunCmd,
    output logic                           manualActive,
    output logic                           altMotorActive,
    output logic [2:0]                     rampSel,
    output logic                           gateEnable,
    output logic                           tripLatched,
    output logic                           stopLedBlink,
    output logic                           loopEnable,
    output logic                           timerOut,
    output logic [31:0]                    activeParams,
    output logic                           irq
);
    import dif_pkg::*;

    // Two-flop synchronizers; the first stage is read only by the second.
    logic [9:0] syncA;
    logic [9:0] syncB;
    always_ff @(posedge ref_clk) begin
        syncA <= {stopPin, revRunPin, fwdRunPin, termIn};
        syncB <= syncA;
    end
    wire [6:0] term = syncB[6:0];
    wire fwdPin = syncB[7];
    wire revPin = syncB[8];
    wire stopP  = syncB[9];

    // Registers.
    logic [FUNC_W-1:0] assignFn [NUM_TERMS];
    logic [1:0]        loopMode;
    logic              runLatchEn;
    logic [31:0]       storedParams;
    logic [31:0]       keypadParams;
    logic [15:0]       riseDelay;
    logic [15:0]       fallDelay;
    logic [IRQ_W-1:0]  irqStat;
    logic [IRQ_W-1:0]  irqMask;

    // Duplicate detection: a later terminal holding an earlier one's code is unused.
    logic [6:0] fnValid;
    wire  [NUM_TERMS*FUNC_W-1:0] assignFlat;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_TERMS; gi++) begin : g_dup
            logic dup;
            always_comb begin
                dup = 1'b0;
                for (int j = 0; j < gi; j++) begin
                    if (assignFn[j] == assignFn[gi]) begin
                        dup = 1'b1;
                    end
                end
            end
            assign fnValid[gi] = (assignFn[gi] != FN_NONE) && !dup;
            assign assignFlat[gi*FUNC_W +: FUNC_W] = assignFn[gi];
        end
    endgenerate

    // Everything the lookup reads is an argument, so the wires below follow every
    // change of the map or the terminals; a function reading module signals would not.
    function automatic logic fnHit(input logic [FUNC_W-1:0]           code,
                                   input logic [NUM_TERMS*FUNC_W-1:0] fns,
                                   input logic [NUM_TERMS-1:0]        qual);
        logic hit;
        hit = 1'b0;
        for (int k = 0; k < NUM_TERMS; k++) begin
            if (qual[k] && fns[k*FUNC_W +: FUNC_W] == code) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    wire [NUM_TERMS-1:0] termOn = fnValid & term;
    wire manualTerm = fnHit(FN_MANUAL, assignFlat, termOn);
    wire altTerm    = fnHit(FN_ALT_MOTOR, assignFlat, termOn);
    wire altDefined = fnHit(FN_ALT_MOTOR, assignFlat, fnValid);
    wire xcelL      = fnHit(FN_XCEL_L, assignFlat, termOn);
    wire xcelH      = fnHit(FN_XCEL_H, assignFlat, termOn);
    wire latchDef   = fnHit(FN_RUN_LATCH, assignFlat, fnValid) && runLatchEn;
    wire tripDef    = fnHit(FN_EXT_TRIP, assignFlat, fnValid);
    wire tripTerm   = fnHit(FN_EXT_TRIP, assignFlat, termOn);
    wire blockPos   = fnHit(FN_BLOCK_POS, assignFlat, termOn);
    wire blockNeg   = fnHit(FN_BLOCK_NEG, assignFlat, termOn);
    wire loopInh    = fnHit(FN_LOOP_INH, assignFlat, termOn);
    wire loopInhDef = fnHit(FN_LOOP_INH, assignFlat, fnValid);
    wire timerIn    = fnHit(FN_TIMER_IN, assignFlat, termOn);
    wire rampBypass = fnHit(FN_RAMP_BYP, assignFlat, termOn);

    // AHB-Lite address phase capture; zero wait states.
    logic       dpWrite;
    logic       dpRead;
    logic [7:0] dpAddr;
    wire addrPhase = hsel && hready && htrans[1];
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            dpWrite <= 1'b0;
            dpRead  <= 1'b0;
            dpAddr  <= 8'h00;
        end else begin
            dpWrite <= addrPhase && hwrite;
            dpRead  <= addrPhase && !hwrite;
            dpAddr  <= haddr;
        end
    end
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    wire running    = !motorStopped;
    wire wrAssign0  = dpWrite && dpAddr == OFS_ASSIGN0;
    wire wrAssign1  = dpWrite && dpAddr == OFS_ASSIGN1;
    wire wrConfig   = dpWrite && dpAddr == OFS_CONFIG;
    wire wrParams   = dpWrite && dpAddr == OFS_PARAMS;
    wire wrDelays   = dpWrite && dpAddr == OFS_DELAYS;
    wire wrIrqStat  = dpWrite && dpAddr == OFS_IRQ_STAT;
    wire wrIrqMask  = dpWrite && dpAddr == OFS_IRQ_MASK;
    wire assignLock = running;
    // Params word: [3:0] run source, [7:4] speed ref source, [11:8] control mode,
    // [15:12] torque limit source, upper bits free.
    wire [31:0] paramMask = altDefined ? 32'h0000_0F00 : 32'h0000_0000;
    wire paramRefused = wrParams && manualActive;
    wire assignRefused = (wrAssign0 || wrAssign1) && assignLock;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            for (int k = 0; k < NUM_TERMS; k++) begin
                assignFn[k] <= FN_NONE;
            end
            loopMode     <= RST_LOOP;
            runLatchEn   <= 1'b0;
            storedParams <= 32'h0000_0000;
            riseDelay    <= RST_DELAY;
            fallDelay    <= RST_DELAY;
            irqMask      <= 4'h0;
        end else begin
            if (wrAssign0 && !assignLock) begin
                for (int k = 0; k < 4; k++) begin
                    assignFn[k] <= hwdata[8*k +: FUNC_W];
                end
            end
            if (wrAssign1 && !assignLock) begin
                for (int k = 4; k < NUM_TERMS; k++) begin
                    assignFn[k] <= hwdata[8*(k-4) +: FUNC_W];
                end
            end
            if (wrConfig) begin
                loopMode   <= (hwdata[1:0] == 2'h3) ? LOOP_TERMINAL : hwdata[1:0];
                runLatchEn <= hwdata[4];
            end
            if (wrParams && !manualActive) begin
                storedParams <= hwdata;
            end else if (wrParams) begin
                storedParams <= (storedParams & ~paramMask) | (hwdata & paramMask);
            end
            if (wrDelays) begin
                riseDelay <= (hwdata[15:0] < 16'h0001) ? 16'h0001 : hwdata[15:0];
                fallDelay <= (hwdata[31:16] < 16'h0001) ? 16'h0001 : hwdata[31:16];
            end
            if (wrIrqMask) begin
                irqMask <= hwdata[IRQ_W-1:0];
            end
        end
    end

    // Manual override: armed on a rising terminal while stopped, keypad copy is scratch.
    logic manualTermQ;
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            manualTermQ  <= 1'b0;
            manualActive <= 1'b0;
            keypadParams <= 32'h0000_0000;
        end else begin
            manualTermQ <= manualTerm;
            if (!manualTerm) begin
                manualActive <= 1'b0;
            end else if (manualTerm && !manualTermQ && motorStopped) begin
                manualActive <= 1'b1;
            end
            if (!manualActive) begin
                keypadParams <= storedParams;
            end else if (keypadWrite) begin
                keypadParams <= keypadData;
            end
        end
    end
    assign activeParams = manualActive ? keypadParams : storedParams;

    // Alternate motor set switches only at standstill.
    logic altPending;
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            altMotorActive <= 1'b0;
        end else if (motorStopped) begin
            altMotorActive <= altTerm;
        end
    end
    assign altPending = altTerm != altMotorActive;

    // Ramp selection: 3'h4 means shortest ramp, otherwise pair index 0..3.
    wire [2:0] next_rampSel = rampBypass ? 3'h4 : {1'b0, xcelH, xcelL};

    // Run latching and external trip.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            fwdRunCmd   <= 1'b0;
            revRunCmd   <= 1'b0;
            tripLatched <= 1'b0;
            rampSel     <= 3'h0;
        end else begin
            rampSel <= next_rampSel;
            if (latchDef) begin
                if (stopP || tripLatched) begin
                    fwdRunCmd <= 1'b0;
                    revRunCmd <= 1'b0;
                end else if (fwdPin) begin
                    fwdRunCmd <= 1'b1;
                    revRunCmd <= 1'b0;
                end else if (revPin) begin
                    revRunCmd <= 1'b1;
                    fwdRunCmd <= 1'b0;
                end
            end else begin
                fwdRunCmd <= fwdPin && !tripLatched;
                revRunCmd <= revPin && !tripLatched;
            end
            if (tripDef && !tripTerm) begin
                tripLatched <= 1'b1;
            end else if (faultReset) begin
                tripLatched <= 1'b0;
            end
        end
    end
    assign gateEnable = !tripLatched;

    // Stop indicator toggles every BLINK_TENTHS tenths while tripped, about 2.5 Hz.
    // It shares the tenth-second base so a short TENTH_CYCLES speeds it up as well.
    logic [31:0] blinkCnt;
    logic [7:0]  blinkTenths;
    wire blinkTick = blinkCnt == 32'(TENTH_CYCLES - 1);
    always_ff @(posedge ref_clk) begin
        if (!rstn || !tripLatched) begin
            blinkCnt     <= 32'h0;
            blinkTenths  <= 8'h0;
            stopLedBlink <= 1'b0;
        end else begin
            blinkCnt <= blinkTick ? 32'h0 : blinkCnt + 32'h1;
            if (blinkTick) begin
                if (blinkTenths == 8'(BLINK_TENTHS - 1)) begin
                    blinkTenths  <= 8'h0;
                    stopLedBlink <= !stopLedBlink;
                end else begin
                    blinkTenths <= blinkTenths + 8'h1;
                end
            end
        end
    end

    // Speed clamp and loop enable.
    wire runCmd = fwdRunCmd || revRunCmd;
    wire loopOk = (loopMode == LOOP_ENABLE) ||
                  (loopMode == LOOP_TERMINAL && loopInhDef && !loopInh);
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            speedCmdOut <= '0;
            loopEnable  <= 1'b0;
        end else begin
            if ((blockPos && speedCmdIn > 0) || (blockNeg && speedCmdIn < 0)) begin
                speedCmdOut <= '0;
            end else begin
                speedCmdOut <= speedCmdIn;
            end
            loopEnable <= runCmd && loopOk && loopOutIn;
        end
    end

    // On/off delay timer, counted in tenths of a second.
    logic [31:0] tickCnt;
    logic [15:0] tenths;
    wire tick = tickCnt == 32'(TENTH_CYCLES - 1);
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            tickCnt  <= 32'h0;
            tenths   <= 16'h0;
            timerOut <= 1'b0;
        end else if (timerIn == timerOut) begin
            tickCnt <= 32'h0;
            tenths  <= 16'h0;
        end else begin
            tickCnt <= tick ? 32'h0 : tickCnt + 32'h1;
            if (tick) begin
                if (tenths + 16'h1 >= (timerIn ? riseDelay : fallDelay)) begin
                    timerOut <= timerIn;
                    tenths   <= 16'h0;
                end else begin
                    tenths <= tenths + 16'h1;
                end
            end
        end
    end

    // Interrupt events; set wins over a write-one clear.
    logic tripQ;
    logic altQ;
    wire [IRQ_W-1:0] irqEvent = {altMotorActive != altQ, paramRefused || assignRefused,
                                 wrAssign0 || wrAssign1, tripLatched && !tripQ};
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            irqStat <= 4'h0;
            tripQ   <= 1'b0;
            altQ    <= 1'b0;
        end else begin
            tripQ   <= tripLatched;
            altQ    <= altMotorActive;
            irqStat <= (irqStat & ~(wrIrqStat ? hwdata[IRQ_W-1:0] : 4'h0)) | irqEvent;
        end
    end
    assign irq = |(irqStat & irqMask);

    // Read mux.
    logic [31:0] rdAssign0;
    logic [31:0] rdAssign1;
    logic [31:0] rdStatus;
    always_comb begin
        rdAssign0 = 32'h0;
        rdAssign1 = 32'h0;
        for (int k = 0; k < 4; k++) begin
            rdAssign0[8*k +: FUNC_W] = fnValid[k] ? assignFn[k] : FN_NONE;
        end
        for (int k = 4; k < NUM_TERMS; k++) begin
            rdAssign1[8*(k-4) +: FUNC_W] = fnValid[k] ? assignFn[k] : FN_NONE;
        end
        rdStatus = {16'h0, 1'b0, term, altPending, loopEnable, timerOut, tripLatched,
                    rampSel[2], altMotorActive, manualActive, motorStopped};
    end
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            hrdata <= 32'h0;
        end else if (addrPhase && !hwrite) begin
            case (haddr)
                OFS_ASSIGN0:  hrdata <= rdAssign0;
                OFS_ASSIGN1:  hrdata <= rdAssign1;
                OFS_CONFIG:   hrdata <= {27'h0, runLatchEn, 2'h0, loopMode};
                OFS_PARAMS:   hrdata <= storedParams;
                OFS_DELAYS:   hrdata <= {fallDelay, riseDelay};
                OFS_STATUS:   hrdata <= rdStatus;
                OFS_IRQ_STAT: hrdata <= {28'h0, irqStat};
                OFS_IRQ_MASK: hrdata <= {28'h0, irqMask};
                OFS_DRIVE:    hrdata <= activeParams;
                default:      hrdata <= 32'h0;
            endcase
        end
    end

    a_alt_deferred: assert property (@(posedge ref_clk) disable iff (!rstn)
        !motorStopped |=> $stable(altMotorActive)) else $error("alt set switched running");
    a_trip_latch: assert property (@(posedge ref_clk) disable iff (!rstn)
        (tripDef && !tripTerm) |=> tripLatched) else $error("trip not latched");
    a_pos_block: assert property (@(posedge ref_clk) disable iff (!rstn)
        (blockPos && speedCmdIn > 0) |=> speedCmdOut == 0) else $error("positive passed");
    a_neg_block: assert property (@(posedge ref_clk) disable iff (!rstn)
        (blockNeg && speedCmdIn < 0) |=> speedCmdOut == 0) else $error("negative passed");
    a_loop_run: assert property (@(posedge ref_clk) disable iff (!rstn)
        loopEnable |-> $past(runCmd)) else $error("loop enabled without run");
    a_loop_mode: assert property (@(posedge ref_clk) disable iff (!rstn)
        loopMode == LOOP_DISABLE |=> !loopEnable) else $error("loop on in disable");
    a_ramp_bypass: assert property (@(posedge ref_clk) disable iff (!rstn)
        rampBypass |=> rampSel == 3'h4) else $error("bypass ignored");
    a_manual_arm: assert property (@(posedge ref_clk) disable iff (!rstn)
        $rose(manualActive) |-> $past(motorStopped)) else $error("override armed running");
    a_param_lock: assert property (@(posedge ref_clk) disable iff (!rstn)
        (paramRefused && !altDefined) |=> $stable(storedParams)) else $error("write taken");
endmodule

// ---- test/dif_switch_model.sv ----
// Model of the external switches that drive the input terminals and run pins.
// Assumes one clock; every level changes by non-blocking assignment after a rising edge.
`timescale 1ns/10ps
module dif_switch_model (
    // Clock
    input  wire logic ref_clk,
    // Terminal and pin levels
    output logic [6:0] termIn,
    output logic       fwdRunPin,
    output logic       revRunPin,
    output logic       stopPin
);
    logic [2:0] pins;

    assign {stopPin, revRunPin, fwdRunPin} = pins;

    // Terminal 4 idles ON because the trip contact there is normally closed.
    initial begin
        termIn = 7'h08;
        pins = 3'h0;
    end

    task automatic setTerm(input int idx, input logic lvl);
        @(posedge ref_clk);
        termIn[idx] <= lvl;
    endtask

    // Momentary press: 0 forward, 1 reverse, 2 stop.
    task automatic press(input int which);
        @(posedge ref_clk);
        pins[which] <= 1'b1;
        repeat (4) @(posedge ref_clk);
        pins[which] <= 1'b0;
    endtask
endmodule

// ---- test/drive_input_function_logic_tb.sv ----
// Self-checking bench for the terminal function decoder.
// Assumes registers on AHB-Lite with hreadyout fed back as hready.
`timescale 1ns/10ps
module drive_input_function_logic_tb;
    import dif_pkg::*;
    logic ref_clk, rstn, hsel, hwrite, keypadWrite, motorStopped, loopOutIn, faultReset;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize, rampSel;
    logic [31:0] hwdata, keypadData, hrdata, activeParams, rd;
    logic signed [15:0] speedCmdIn, speedCmdOut;
    logic [6:0] termIn;
    logic fwdRunPin, revRunPin, stopPin, hreadyout, hresp, fwdRunCmd, revRunCmd;
    logic manualActive, altMotorActive, gateEnable, tripLatched, stopLedBlink;
    logic loopEnable, timerOut, irq;
    int failures, nChecks;

    dif_switch_model u_sw (.ref_clk(ref_clk), .termIn(termIn), .fwdRunPin(fwdRunPin),
        .revRunPin(revRunPin), .stopPin(stopPin));

    // A tenth of a second shrinks to ten cycles so the delays stay short.
    dif_input_logic #(.TENTH_CYCLES(10)) u_dut (.ref_clk(ref_clk), .rstn(rstn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .termIn(termIn), .fwdRunPin(fwdRunPin), .revRunPin(revRunPin), .stopPin(stopPin),
        .motorStopped(motorStopped), .keypadWrite(keypadWrite), .keypadData(keypadData),
        .speedCmdIn(speedCmdIn), .loopOutIn(loopOutIn), .faultReset(faultReset),
        .speedCmdOut(speedCmdOut), .fwdRunCmd(fwdRunCmd), .revRunCmd(revRunCmd),
        .manualActive(manualActive), .altMotorActive(altMotorActive), .rampSel(rampSel),
        .gateEnable(gateEnable), .tripLatched(tripLatched), .stopLedBlink(stopLedBlink),
        .loopEnable(loopEnable), .timerOut(timerOut), .activeParams(activeParams), .irq(irq));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic w(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        nChecks++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    // One single transfer; the address phase holds until hready, then the data phase.
    task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic endSim();
        $display("checks %0d failures %0d", nChecks, failures);
        if (failures == 0 && nChecks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        endSim();
    end

    initial begin
        {rstn, hsel, hwrite, keypadWrite, loopOutIn, faultReset} = 6'h0;
        {haddr, htrans, hwdata, keypadData, speedCmdIn} = '0;
        hsize = 3'h2;
        motorStopped = 1'b1;
        w(20);
        rstn <= 1'b1;
        chk("gateEnable", 1, gateEnable);
        chk("hresp", 0, hresp);
        bus(OFS_DELAYS, 0, 0);
        chk("delays", 32'h000A000A, rd);
        bus(8'h24, 0, 0);
        chk("unmapped", 0, rd);
        bus(OFS_ASSIGN0, 1, 32'h0F140D0C);
        bus(OFS_ASSIGN1, 1, 32'h000A1110);
        bus(OFS_ASSIGN0, 0, 0);
        chk("assign0", 32'h0F140D0C, rd);
        bus(OFS_IRQ_STAT, 1, 32'hF);
        bus(OFS_IRQ_MASK, 1, 32'hF);
        for (int k = 0; k < 4; k++) begin
            u_sw.setTerm(0, k[0]);
            u_sw.setTerm(1, k[1]);
            w(6);
            chk("rampSel", k, rampSel);
        end
        u_sw.setTerm(2, 1);
        w(6);
        chk("rampSel bypass", 4, rampSel);
        u_sw.setTerm(0, 0);
        u_sw.setTerm(1, 0);
        u_sw.setTerm(2, 0);
        speedCmdIn <= 100;
        u_sw.setTerm(4, 1);
        w(6);
        chk("speed pos blocked", 0, speedCmdOut);
        speedCmdIn <= -100;
        w(4);
        chk("speed neg passed", -100, speedCmdOut);
        u_sw.setTerm(4, 0);
        u_sw.setTerm(5, 1);
        w(6);
        chk("speed neg blocked", 0, speedCmdOut);
        speedCmdIn <= 100;
        w(4);
        chk("speed pos passed", 100, speedCmdOut);
        u_sw.setTerm(5, 0);
        u_sw.setTerm(3, 0);
        w(6);
        chk("trip", 1, tripLatched);
        chk("gate off", 0, gateEnable);
        chk("irq trip", 1, irq);
        u_sw.setTerm(3, 1);
        w(6);
        chk("trip held", 1, tripLatched);
        bus(OFS_IRQ_STAT, 0, 0);
        chk("irq stat trip", 1, rd[IRQ_TRIP]);
        bus(OFS_IRQ_MASK, 1, 0);
        w(2);
        chk("irq masked", 0, irq);
        w(8);
        chk("stop blink", 1, stopLedBlink);
        faultReset <= 1'b1;
        w(3);
        faultReset <= 1'b0;
        w(3);
        chk("trip cleared", 0, tripLatched);
        chk("blink cleared", 0, stopLedBlink);
        bus(OFS_IRQ_STAT, 1, 32'hF);
        bus(OFS_IRQ_MASK, 1, 32'hF);
        w(2);
        chk("irq cleared", 0, irq);
        // Manual override: refused while running, taken on an edge while stopped.
        bus(OFS_PARAMS, 1, 32'h4321);
        motorStopped <= 1'b0;
        u_sw.setTerm(6, 1);
        w(6);
        chk("manual running", 0, manualActive);
        u_sw.setTerm(6, 0);
        motorStopped <= 1'b1;
        w(2);
        u_sw.setTerm(6, 1);
        w(6);
        chk("manual", 1, manualActive);
        bus(OFS_PARAMS, 1, 32'h1234);
        bus(OFS_PARAMS, 0, 0);
        chk("params locked", 32'h4321, rd);
        bus(OFS_IRQ_STAT, 0, 0);
        chk("irq refused", 1, rd[IRQ_REFUSED]);
        @(posedge ref_clk);
        keypadWrite <= 1'b1;
        keypadData <= 32'hABCD;
        @(posedge ref_clk);
        keypadWrite <= 1'b0;
        w(3);
        chk("keypad params", 32'hABCD, activeParams);
        u_sw.setTerm(6, 0);
        w(6);
        chk("params restored", 32'h4321, activeParams);
        keypadData <= 32'h5A5A;
        keypadWrite <= 1'b1;
        w(1);
        keypadWrite <= 1'b0;
        w(3);
        chk("keypad ignored", 32'h4321, activeParams);
        // Terminal 7 now carries run latching.
        bus(OFS_ASSIGN1, 1, 32'h000E1110);
        loopOutIn <= 1'b1;
        bus(OFS_CONFIG, 1, 32'h11);
        u_sw.press(0);
        w(6);
        chk("fwd latched", 1, fwdRunCmd);
        chk("loop enable", 1, loopEnable);
        loopOutIn <= 1'b0;
        w(3);
        chk("loop no demand", 0, loopEnable);
        loopOutIn <= 1'b1;
        u_sw.press(2);
        w(6);
        chk("fwd stopped", 0, fwdRunCmd);
        chk("loop no run", 0, loopEnable);
        u_sw.press(1);
        w(6);
        chk("rev latched", 1, revRunCmd);
        bus(OFS_CONFIG, 1, 32'h10);
        w(3);
        chk("loop disabled", 0, loopEnable);
        u_sw.press(2);
        // Second terminal map: alt motor, loop inhibit and timer input.
        bus(OFS_ASSIGN0, 1, 32'h0E13120B);
        bus(OFS_ASSIGN1, 1, 32'h0000000B);
        bus(OFS_ASSIGN1, 0, 0);
        chk("duplicate unused", 0, rd);
        motorStopped <= 1'b0;
        bus(OFS_ASSIGN1, 1, 32'h00000010);
        bus(OFS_ASSIGN1, 0, 0);
        chk("assign locked", 0, rd);
        u_sw.setTerm(0, 1);
        w(6);
        chk("alt deferred", 0, altMotorActive);
        motorStopped <= 1'b1;
        w(6);
        chk("alt active", 1, altMotorActive);
        bus(OFS_IRQ_STAT, 0, 0);
        chk("irq alt switch", 1, rd[IRQ_SWITCH]);
        bus(OFS_CONFIG, 1, 32'h12);
        u_sw.press(0);
        w(6);
        chk("loop terminal", 1, loopEnable);
        u_sw.setTerm(1, 1);
        w(6);
        chk("loop inhibited", 0, loopEnable);
        u_sw.press(2);
        bus(OFS_DELAYS, 1, 32'h00030002);
        u_sw.setTerm(2, 1);
        w(16);
        chk("timer rise early", 0, timerOut);
        w(12);
        chk("timer rise", 1, timerOut);
        u_sw.setTerm(2, 0);
        w(26);
        chk("timer fall early", 1, timerOut);
        w(12);
        chk("timer fall", 0, timerOut);
        endSim();
    end
endmodule
